// File: core/asr_rx.sv
`timescale 1ns/1ns
`include "asr_consts.svh"
// Behaviour
// - Recovery stage runs at sixteen per bit
// - Shift register advances once per bit
// - Reception needs continuous receive enable set
// - Stop bit moves frame, sets done flag
// - Interrupt request gated by receive interrupt enable
// - Done flag read-only, clears when empty
// - Two-entry FIFO, reads in arrival order
// - Full FIFO at stop sets overrun, drops
// - Overrun blocks every transfer into FIFO
// - Overrun cleared only by receive enable reset
// - Stop bit low sets framing error
// - Error and ninth bit queued per entry
// - Bit level by three-sample majority vote
// - Samples on seventh, eighth, ninth edges
// - Sampling clock free-running, window every sixteen
// - Nine-bit select captures ninth data bit
// - Clearing enables stops and resets receiver
// - Start, eight or nine data, stop
// - Reception halts during sleep
module asr_rx #(
  parameter int AW = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          sleep,
  input  wire logic          receive_pin,
  output logic               rx_irq,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  // ========================================================
  // Address decode
  function automatic asr_pkg::asr_reg_e reg_sel(
    input logic [AW-1:0] a
  );
    logic [AW-1:0] b1;
    b1 = AW'(`ASR_BANK1_BASE);
    reg_sel = asr_pkg::ASR_R_NONE;
    if (a == AW'({`ASR_IDX_RX_STATUS, 2'b00}))
      reg_sel = asr_pkg::ASR_R_RXSTAT;
    else if (a == AW'({`ASR_IDX_RX_DATA, 2'b00}))
      reg_sel = asr_pkg::ASR_R_RXDATA;
    else if (a == AW'({`ASR_IDX_TX_STATUS, 2'b00}))
      reg_sel = asr_pkg::ASR_R_TXSTAT;
    else if (a == AW'({`ASR_IDX_TX_DATA, 2'b00}))
      reg_sel = asr_pkg::ASR_R_TXDATA;
    else if (a == AW'({`ASR_IDX_BAUD_DIV, 2'b00}))
      reg_sel = asr_pkg::ASR_R_BAUD;
    else if (a == b1 + AW'({`ASR_IDX_IRQ_FLAGS, 2'b00}))
      reg_sel = asr_pkg::ASR_R_FLAGS;
    else if (a == b1 + AW'({`ASR_IDX_IRQ_ENABLES, 2'b00}))
      reg_sel = asr_pkg::ASR_R_ENABLES;
  endfunction : reg_sel

  // ========================================================
  // Registers
  logic [3:0]            rx_ctrl_q;
  logic [7:0]            tx_status_q;
  logic [7:0]            tx_data_q;
  logic [7:0]            flags_q;
  logic [7:0]            enables_q;
  logic [7:0]            baud_div_q;
  logic                  overrun_q;
  logic                  serial_port_enable;
  logic                  nine_bit_receive_select;
  logic                  single_receive_enable;
  logic                  continuous_receive_enable;
  logic                  rx_reset;
  logic                  rx_run;

  assign serial_port_enable        = rx_ctrl_q[3];
  assign nine_bit_receive_select   = rx_ctrl_q[2];
  assign single_receive_enable     = rx_ctrl_q[1];
  assign continuous_receive_enable = rx_ctrl_q[0];
  // Receive logic held idle unless the port and an enable are on
  assign rx_reset = !serial_port_enable ||
                    !(single_receive_enable ||
                      continuous_receive_enable);
  // Sleep only freezes progress; it does not reset the frame
  assign rx_run = !rx_reset && continuous_receive_enable &&
                  !tx_status_q[`ASR_BIT_SYNC_SEL] &&
                  !sleep;

  // ========================================================
  // AXI4-Lite write channel
  logic            aw_have_q;
  logic            w_have_q;
  logic [AW-1:0]   aw_addr_q;
  logic [7:0]      w_byte_q;
  logic            w_lane_q;
  logic            wr_fire;
  asr_pkg::asr_reg_e wr_sel;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_sel        = reg_sel(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_byte_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == asr_pkg::ASR_R_NONE) ?
                        `ASR_RESP_SLVERR : `ASR_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_en;
  assign wr_en = wr_fire && w_lane_q;

  // In the receive status register only control bits are writable; its status bits read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ctrl_q   <= `ASR_RST_RX_CTRL;
      tx_status_q <= `ASR_RST_TX_STATUS;
      tx_data_q   <= `ASR_RST_TX_DATA;
      flags_q     <= `ASR_RST_IRQ_FLAGS;
      enables_q   <= `ASR_RST_IRQ_ENABLES;
      baud_div_q  <= `ASR_RST_BAUD_DIV;
    end else if (ce && wr_en) begin
      case (wr_sel)
        asr_pkg::ASR_R_RXSTAT:  rx_ctrl_q   <= w_byte_q[7:4];
        asr_pkg::ASR_R_TXSTAT:  tx_status_q <= w_byte_q;
        asr_pkg::ASR_R_TXDATA:  tx_data_q   <= w_byte_q;
        asr_pkg::ASR_R_FLAGS:   flags_q     <= w_byte_q;
        asr_pkg::ASR_R_BAUD:    baud_div_q  <= w_byte_q;
        asr_pkg::ASR_R_ENABLES: enables_q   <= w_byte_q;
        default: ;
      endcase
    end
  end

  // ========================================================
  // Receive FIFO, two entries
  asr_pkg::asr_entry_s fifo_mem [2];
  logic                wr_ptr_q;
  logic                rd_ptr_q;
  logic [1:0]          count_q;
  logic                push;
  logic                pop;
  logic                fifo_full;
  asr_pkg::asr_entry_s head;
  asr_pkg::asr_entry_s frame_d;

  assign fifo_full = (count_q == 2'h2);
  assign head      = fifo_mem[rd_ptr_q];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else if (ce) begin
      if (push) begin
        fifo_mem[wr_ptr_q] <= frame_d;
        wr_ptr_q           <= !wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= !rd_ptr_q;
      // Push and pop together keep the count, so no frame is lost
      if (push && !pop)
        count_q <= count_q + 2'h1;
      else if (pop && !push)
        count_q <= count_q - 2'h1;
    end
  end

  // ========================================================
  // AXI4-Lite read channel; reading data pops the FIFO
  logic              rd_fire;
  asr_pkg::asr_reg_e rd_sel;
  logic [7:0]        rd_byte;
  logic              rx_done;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_sel        = reg_sel(s_axi_araddr);
  assign rx_done       = (count_q != 2'h0);
  assign pop           = ce && rd_fire &&
                         rd_sel == asr_pkg::ASR_R_RXDATA &&
                         rx_done;

  always_comb begin
    rd_byte = 8'h00;
    case (rd_sel)
      asr_pkg::ASR_R_RXSTAT: begin
        rd_byte[7:4]                = rx_ctrl_q;
        rd_byte[`ASR_BIT_FRAME_ERR] = rx_done && head.frame_err;
        rd_byte[`ASR_BIT_OVERRUN]   = overrun_q;
        rd_byte[`ASR_BIT_NINTH]     = rx_done && head.ninth;
      end
      asr_pkg::ASR_R_RXDATA:  rd_byte = rx_done ? head.data : 8'h00;
      asr_pkg::ASR_R_TXSTAT:  rd_byte = tx_status_q;
      asr_pkg::ASR_R_TXDATA:  rd_byte = tx_data_q;
      asr_pkg::ASR_R_FLAGS: begin
        rd_byte                   = flags_q;
        rd_byte[`ASR_BIT_RX_DONE] = rx_done;
      end
      asr_pkg::ASR_R_BAUD:    rd_byte = baud_div_q;
      asr_pkg::ASR_R_ENABLES: rd_byte = enables_q;
      default:                rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ASR_RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= (rd_sel == asr_pkg::ASR_R_NONE) ?
                        `ASR_RESP_SLVERR : `ASR_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Request follows the flag only while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_irq <= 1'b0;
    else if (ce)
      rx_irq <= rx_done && enables_q[`ASR_BIT_RX_IE];
  end

  // ========================================================
  // Pin synchroniser and sixteen-phase tick
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       pin_prev_q;
  logic [7:0] baud_cnt_q;
  logic       tick;
  logic [3:0] phase_q;
  logic       start_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q   <= 1'b1;
      pin_s2_q   <= 1'b1;
      pin_prev_q <= 1'b1;
    end else if (ce) begin
      pin_s1_q   <= receive_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Divisor value N gives one sampling tick every N+1 cycles
  assign tick = (baud_cnt_q == baud_div_q);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      baud_cnt_q <= 8'h00;
    else if (ce) begin
      if (rx_reset || tick)
        baud_cnt_q <= 8'h00;
      else
        baud_cnt_q <= baud_cnt_q + 8'h01;
    end
  end

  asr_pkg::asr_state_e state_q;

  assign start_edge = rx_run && state_q == asr_pkg::ASR_IDLE &&
                      pin_prev_q && !pin_s2_q;

  // Phase counter wraps freely and is only re-aligned at start
  always_ff @(posedge aclk) begin
    if (!aresetn)
      phase_q <= 4'h0;
    else if (ce) begin
      if (start_edge)
        phase_q <= 4'h0;
      else if (tick)
        phase_q <= phase_q + 4'h1;
    end
  end

  // ========================================================
  // Majority sampling
  logic [1:0] smp_q;
  logic       vote_now;
  logic       vote;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      smp_q <= 2'b11;
    else if (ce && tick) begin
      if (phase_q == `ASR_SMP_FIRST)
        smp_q[0] <= pin_s2_q;
      if (phase_q == `ASR_SMP_SECOND)
        smp_q[1] <= pin_s2_q;
    end
  end

  assign vote_now = tick && !start_edge &&
                    phase_q == `ASR_SMP_LAST;
  assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & pin_s2_q) |
                (smp_q[1] & pin_s2_q);

  // ========================================================
  // Frame state machine and receive shift register
  logic [8:0] rsr_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bits_needed;
  logic       stop_seen;

  assign bits_needed = nine_bit_receive_select ? 4'h9 : 4'h8;
  assign stop_seen   = rx_run && vote_now &&
                       state_q == asr_pkg::ASR_STOP;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= asr_pkg::ASR_IDLE;
      rsr_q     <= 9'h000;
      bit_cnt_q <= 4'h0;
    end else if (ce) begin
      if (rx_reset) begin
        state_q   <= asr_pkg::ASR_IDLE;
        bit_cnt_q <= 4'h0;
      end else if (start_edge) begin
        state_q   <= asr_pkg::ASR_START;
        bit_cnt_q <= 4'h0;
      end else if (rx_run && vote_now) begin
        case (state_q)
          asr_pkg::ASR_START:
            // A start that votes high was a glitch
            state_q <= vote ? asr_pkg::ASR_IDLE
                            : asr_pkg::ASR_DATA;
          asr_pkg::ASR_DATA: begin
            rsr_q     <= {vote, rsr_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q + 4'h1 == bits_needed)
              state_q <= asr_pkg::ASR_STOP;
          end
          asr_pkg::ASR_STOP: state_q <= asr_pkg::ASR_IDLE;
          default:           state_q <= asr_pkg::ASR_IDLE;
        endcase
      end
    end
  end

  // Eight-bit frames leave the data one place higher in the shifter
  always_comb begin
    frame_d.frame_err = !vote;
    if (nine_bit_receive_select) begin
      frame_d.data  = rsr_q[7:0];
      frame_d.ninth = rsr_q[8];
    end else begin
      frame_d.data  = rsr_q[8:1];
      frame_d.ninth = 1'b0;
    end
  end

  // A pop in the same cycle frees no room for this frame
  assign push = ce && stop_seen && !overrun_q &&
                !fifo_full;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      overrun_q <= 1'b0;
    else if (ce) begin
      if (stop_seen && !overrun_q && fifo_full)
        overrun_q <= 1'b1;
      else if (rx_reset)
        overrun_q <= 1'b0;
    end
  end
endmodule : asr_rx

// File: core/asr_consts.svh
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// ==========================================================
// Register indices; byte address is four times the index
`define ASR_IDX_RX_STATUS   8'h13
`define ASR_IDX_RX_DATA     8'h14
`define ASR_IDX_TX_STATUS   8'h15
`define ASR_IDX_TX_DATA     8'h16
`define ASR_IDX_IRQ_FLAGS   8'h16
`define ASR_IDX_BAUD_DIV    8'h17
`define ASR_IDX_IRQ_ENABLES 8'h17
// Second bank sits above the first at this byte offset
`define ASR_BANK1_BASE      12'h100
// ==========================================================
// Field positions
`define ASR_BIT_SERIAL_EN   7
`define ASR_BIT_NINE_SEL    6
`define ASR_BIT_SINGLE_EN   5
`define ASR_BIT_CONT_EN     4
`define ASR_BIT_FRAME_ERR   2
`define ASR_BIT_OVERRUN     1
`define ASR_BIT_NINTH       0
`define ASR_BIT_SYNC_SEL    4
`define ASR_BIT_RX_DONE     0
`define ASR_BIT_RX_IE       0
// ==========================================================
// Reset values
`define ASR_RST_RX_CTRL     4'h0
`define ASR_RST_TX_STATUS   8'h00
`define ASR_RST_TX_DATA     8'h00
`define ASR_RST_IRQ_FLAGS   8'h02
`define ASR_RST_IRQ_ENABLES 8'h00
`define ASR_RST_BAUD_DIV    8'h00
// ==========================================================
// Sampling: sixteen phases per bit, votes on phases 6, 7, 8
`define ASR_PHASES          16
`define ASR_SMP_FIRST       4'h6
`define ASR_SMP_SECOND      4'h7
`define ASR_SMP_LAST        4'h8
`define ASR_RESP_OKAY       2'h0
`define ASR_RESP_SLVERR     2'h2
`endif

// File: core/asr_pkg.sv
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_IDLE  = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA  = 2'b10,
    ASR_STOP  = 2'b11
  } asr_state_e;

  typedef enum logic [2:0] {
    ASR_R_NONE    = 3'b000,
    ASR_R_RXSTAT  = 3'b001,
    ASR_R_RXDATA  = 3'b010,
    ASR_R_TXSTAT  = 3'b011,
    ASR_R_TXDATA  = 3'b100,
    ASR_R_FLAGS   = 3'b101,
    ASR_R_BAUD    = 3'b110,
    ASR_R_ENABLES = 3'b111
  } asr_reg_e;

  typedef struct packed {
    logic       frame_err;
    logic       ninth;
    logic [7:0] data;
  } asr_entry_s;
endpackage : asr_pkg

// File: tb/asr_rx_chk.sv
`timescale 1ns/1ns
module asr_rx_chk #(
  parameter int AW = 12
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          sleep,
  input wire logic          rx_irq,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       aw_hs;
  logic       ar_hs;
  logic [2:0] idle_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // Cycles since software last touched a register, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || aw_hs || ar_hs) idle_q <= 3'h0;
    else if (idle_q != 3'h7) idle_q <= idle_q + 3'h1;
  end
  function automatic logic unmapped(input logic [AW-1:0] a);
    return !(a inside {12'h04C, 12'h050, 12'h054, 12'h058, 12'h05C,
                       12'h158, 12'h15C});
  endfunction : unmapped
  // ==========================================================
  // Bus handshake
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response withdrawn");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data withdrawn");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while response pending");
  property p_rd_latency;
    ar_hs |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read answer late");
  property p_rd_bad;
    ar_hs && unmapped(s_axi_araddr) |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad)
    else $error("unmapped read not refused");
  property p_wr_bad;
    aw_hs && s_axi_wvalid && s_axi_wready && unmapped(s_axi_awaddr) |->
      ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  a_wr_bad: assert property (p_wr_bad)
    else $error("unmapped write not refused");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read bits not zero");
  // ==========================================================
  // Receive request
  property p_irq_fall;
    $fell(rx_irq) |-> idle_q < 3'h5;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without software access");
  property p_sleep_quiet;
    (sleep && !s_axi_bvalid)[*3] |-> !$rose(rx_irq);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("reception during sleep");
endmodule : asr_rx_chk

bind asr_rx asr_rx_chk #(.AW(AW)) asr_rx_chk_i (
  .aclk(aclk), .aresetn(aresetn), .sleep(sleep), .rx_irq(rx_irq),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// File: tb/asr_line_model.sv
`timescale 1ns/1ns
module asr_line_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic aclk,
  output logic      line
);
  initial line = 1'b1;
  task automatic send(input logic [8:0] d,
                      input int         nb,
                      input logic       stop,
                      input int         g);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
      for (int k = 0; k < BIT_CYC; k++) begin
        // One-cycle spike can reach at most one of the three votes
        line <= (k == g && i > 0 && i <= nb) ? ~b : b;
        @(posedge aclk);
      end
    end
    // Idle high between frames, so a low stop bit still leaves a start edge
    line <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : send
endmodule : asr_line_model

// File: tb/asr_rx_tb_top.sv
`timescale 1ns/1ns
module asr_rx_tb_top;
  localparam logic [11:0] A_CTRL = 12'h04C;
  localparam logic [11:0] A_DATA = 12'h050;
  localparam logic [11:0] A_TXS  = 12'h054;
  localparam logic [11:0] A_BAUD = 12'h05C;
  localparam logic [11:0] A_FLAG = 12'h158;
  localparam logic [11:0] A_IE   = 12'h15C;
  localparam logic [11:0] A_BAD  = 12'h060;
  localparam logic [1:0]  OK     = 2'h0;
  localparam logic [1:0]  ERR    = 2'h2;
  logic        aclk, aresetn, sleep, receive_pin, rx_irq, ce;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          fails, samples_checked;

  // Divisor 1 gives a tick every 2 cycles, so 32 cycles per bit
  asr_line_model #(.BIT_CYC(32)) asr_line_model_i (
    .aclk(aclk), .line(receive_pin));
  asr_rx #(.AW(12)) asr_rx_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .sleep(sleep),
    .receive_pin(receive_pin), .rx_irq(rx_irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  always #4 aclk = ~aclk;
  // ==========================================================
  // Reporting
  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic timed_out();
    fails++;
    $display("unexpected at %0t: bus answer missing", $time);
    final_report();
  endtask : timed_out
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    if (!bvalid) timed_out();
    bready <= 1'b0;
    chk({bresp, 8'h0}, {er, 8'h0});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    if (!rvalid) timed_out();
    rready <= 1'b0;
    chk({rresp, rdata[7:0]}, {er, ed});
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(A_CTRL, 8'h00, OK);
    rd(A_FLAG, 8'h02, OK);
    rd(A_IE, 8'h00, OK);
    rd(A_TXS, 8'h00, OK);
    rd(A_BAD, 8'h00, ERR);
    wr(A_BAD, 8'hFF, ERR);
    wr(A_FLAG, 8'h03, OK);
    rd(A_FLAG, 8'h02, OK);
    wr(A_CTRL, 8'h07, OK);
    rd(A_CTRL, 8'h00, OK);
  endtask : t_regs
  task automatic t_disabled();
    wr(A_BAUD, 8'h01, OK);
    wr(A_TXS, 8'h00, OK);
    wr(A_CTRL, 8'h80, OK);
    rd(A_BAUD, 8'h01, OK);
    asr_line_model_i.send(9'h05A, 8, 1'b1, -1);
    rd(A_FLAG, 8'h02, OK);
    // Single enable alone keeps the logic out of reset but does not receive
    wr(A_CTRL, 8'hA0, OK);
    asr_line_model_i.send(9'h05A, 8, 1'b1, -1);
    rd(A_FLAG, 8'h02, OK);
    wr(A_TXS, 8'h10, OK);
    wr(A_CTRL, 8'h90, OK);
    asr_line_model_i.send(9'h05A, 8, 1'b1, -1);
    rd(A_FLAG, 8'h02, OK);
    wr(A_TXS, 8'h00, OK);
  endtask : t_disabled
  task automatic t_fifo();
    wr(A_IE, 8'h01, OK);
    wr(A_CTRL, 8'h90, OK);
    asr_line_model_i.send(9'h0A5, 8, 1'b1, 16);
    chk({9'h0, rx_irq}, 10'h001);
    wr(A_IE, 8'h00, OK);
    @(posedge aclk);
    chk({9'h0, rx_irq}, 10'h000);
    rd(A_FLAG, 8'h03, OK);
    wr(A_IE, 8'h01, OK);
    asr_line_model_i.send(9'h03C, 8, 1'b1, 3);
    asr_line_model_i.send(9'h0C3, 8, 1'b1, -1);
    rd(A_CTRL, 8'h92, OK);
    rd(A_DATA, 8'hA5, OK);
    rd(A_DATA, 8'h3C, OK);
    rd(A_FLAG, 8'h02, OK);
    chk({9'h0, rx_irq}, 10'h000);
    asr_line_model_i.send(9'h0D2, 8, 1'b1, -1);
    rd(A_FLAG, 8'h02, OK);
    wr(A_CTRL, 8'h80, OK);
    wr(A_CTRL, 8'h90, OK);
    rd(A_CTRL, 8'h90, OK);
    asr_line_model_i.send(9'h081, 8, 1'b1, -1);
    rd(A_DATA, 8'h81, OK);
  endtask : t_fifo
  task automatic t_ninth();
    wr(A_CTRL, 8'hD0, OK);
    asr_line_model_i.send(9'h133, 9, 1'b0, -1);
    asr_line_model_i.send(9'h044, 9, 1'b1, -1);
    rd(A_CTRL, 8'hD5, OK);
    rd(A_DATA, 8'h33, OK);
    rd(A_CTRL, 8'hD0, OK);
    rd(A_DATA, 8'h44, OK);
  endtask : t_ninth
  task automatic t_sleep();
    wr(A_CTRL, 8'h90, OK);
    sleep <= 1'b1;
    asr_line_model_i.send(9'h011, 8, 1'b1, -1);
    sleep <= 1'b0;
    rd(A_FLAG, 8'h02, OK);
    chk({9'h0, rx_irq}, 10'h000);
    // Frozen enable: a whole frame on the line must leave no trace
    ce <= 1'b0;
    asr_line_model_i.send(9'h011, 8, 1'b1, -1);
    ce <= 1'b1;
    rd(A_FLAG, 8'h02, OK);
    chk({9'h0, rx_irq}, 10'h000);
  endtask : t_sleep

  initial begin
    aclk    = 1'b0;
    aresetn = 1'b0;
    sleep   = 1'b0;
    ce      = 1'b1;
    awaddr  = 12'h000;
    araddr  = 12'h000;
    wdata   = 32'h0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    fails   = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_disabled();
    t_fifo();
    t_ninth();
    t_sleep();
    final_report();
  end
endmodule : asr_rx_tb_top
